// [sim/test_acquisition_trigger_status.sv]
`timescale 1ns/100ps
`default_nettype none
module test_acquisition_trigger_status;
   import acq_status_pkg::*;
   logic clk, rst_n, wr, rd, acq_pin, frame_pin;
   logic exp_act, flash, aw, fw, line1, aot, fot;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d;
   int seed, err_count, check_count, cyc, n_aot, n_fot, e, n, f, ex;
   bit gm;

   acquisition_trigger_status acquisition_trigger_status_i (
      .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .ext_acq_start_trigger_in_i(acq_pin),
      .ext_frame_start_trigger_in_i(frame_pin), .exposure_active_out_o(exp_act),
      .flash_window_out_o(flash), .acq_trigger_wait_o(aw), .frame_trigger_wait_o(fw),
      .line1_out_o(line1), .acq_overtrig_o(aot), .frame_overtrig_o(fot));
   trig_source trig_source_i (.clk_i(clk), .acq_wait_i(aw), .frame_wait_i(fw),
      .acq_pin_o(acq_pin), .frame_pin_o(frame_pin));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task results;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      if (got !== exp) begin
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
      check_count++;
   endtask

   function automatic logic exp_line(input logic [2:0] src, input logic a, input logic fr);
      return (src == LSRC_ACQ_WAIT) ? a : ((src == LSRC_FRAME_WAIT) ? fr : 1'b0);
   endfunction

   function automatic logic sig(input int w);
      case (w)
         0: return aw;
         1: return fw;
         2: return exp_act;
         default: return flash;
      endcase
   endfunction

   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   task wait_for(input int w, input logic v);
      int k;
      k = 0;
      while (sig(w) !== v && k < 1000) begin
         @(posedge clk);
         #1 k++;
      end
      chk(sig(w), v);
   endtask

   // Overtrigger pulses tallied, global flash compared every cycle
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (aot === 1'b1) n_aot <= n_aot + 1;
      if (fot === 1'b1) n_fot <= n_fot + 1;
      if (gm) chk(flash, exp_act);
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end

   initial begin
      {rst_n, wr, rd, addr, wdata, gm} = '0;
      {err_count, check_count, cyc, n_aot, n_fot} = '0;
      seed = 32'h90e4;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({aw, fw, exp_act, flash, line1, aot, fot}, 7'h00);
      rd_reg(OFS_STATUS, d);
      chk(d[0], 1'b1);
      rd_reg(8'h3C, d);
      chk(d, 32'h0000_0000);
      $display("reset test done");
      wr_reg(OFS_CTRL, 32'h0000_0037);
      wait_for(0, 1'b1);
      repeat (2) @(posedge clk);
      #1 chk(line1, 1'b1);
      trig_source_i.fire(0, 1);
      wait_for(0, 1'b0);
      wait_for(1, 1'b1);
      wr_reg(OFS_STATUS_SEL, 32'h0000_0001);
      rd_reg(OFS_STATUS, d);
      chk(d[0], 1'b1);
      wr_reg(OFS_STATUS_SEL, 32'h0000_0000);
      rd_reg(OFS_STATUS, d);
      chk(d[0], 1'b0);
      for (int s = 0; s < 5; s++) begin
         wr_reg(OFS_CTRL, {25'h0, s[2:0], 4'h7});
         repeat (2) @(posedge clk);
         #1 chk(line1, exp_line(s[2:0], 1'b0, 1'b1));
      end
      e = n_aot;
      trig_source_i.fire(0, 0);
      wr_reg(OFS_SW_TRIG, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk(n_aot - e, 2);
      $display("acquisition wait test done");
      ex = 4 + ({$random(seed)} % 16);
      wr_reg(OFS_EXPOSURE, ex);
      wr_reg(OFS_READOUT, 32'h0000_001E);
      gm = 1;
      n = 0;
      fork
         trig_source_i.fire(1, 1);
         begin
            wait_for(2, 1'b1);
            chk(fw, 1'b0);
            while (exp_act === 1'b1 && n < 100) begin
               @(posedge clk);
               #1 n++;
            end
         end
      join
      chk(n, ex);
      chk(aw, 1'b0);
      e = n_fot;
      wr_reg(OFS_SW_TRIG, 32'h0000_0002);
      trig_source_i.fire(1, 0);
      chk(n_fot - e, 2);
      wait_for(0, 1'b1);
      chk(fw, 1'b0);
      rd_reg(OFS_OVERTRIG, d);
      chk(d, {n_fot[15:0], n_aot[15:0]});
      wr_reg(OFS_OVERTRIG, 32'h0000_0000);
      rd_reg(OFS_OVERTRIG, d);
      chk(d, 32'h0000_0000);
      $display("frame and overtrigger test done");
      wr_reg(OFS_CTRL, 32'h0000_0004);
      repeat (3) @(posedge clk);
      #1 chk(aw, 1'b0);
      wr_reg(OFS_SW_TRIG, 32'h0000_0001);
      wr_reg(OFS_STATUS_SEL, 32'h0000_0001);
      rd_reg(OFS_STATUS, d);
      chk(d[0], 1'b1);
      chk(fw, 1'b0);
      wr_reg(OFS_SW_TRIG, 32'h0000_0002);
      wait_for(2, 1'b1);
      wait_for(2, 1'b0);
      gm = 0;
      // Readout of 30 cycles must finish before the shutter mode changes
      repeat (40) @(posedge clk);
      e = 1 + ({$random(seed)} % 3);
      wr_reg(OFS_FLASH_DELAY, e);
      wr_reg(OFS_CTRL, 32'h0000_0028);
      wr_reg(OFS_SW_TRIG, 32'h0000_0001);
      wait_for(2, 1'b1);
      f = 0;
      n = 0;
      while (exp_act === 1'b1 && f < 100) begin
         if (flash === 1'b1) n++;
         chk(line1, flash);
         @(posedge clk);
         #1 f++;
      end
      chk(f, ex);
      chk(n > 0 && n < f, 1'b1);
      chk(n, ex - e);
      repeat (2) @(posedge clk);
      #1 chk(flash, 1'b0);
      $display("flash window test done");
      results();
   end
endmodule
`default_nettype wire

// [sim/trig_source.sv]
`timescale 1ns/100ps
`default_nettype none
module trig_source (
   // Clock and wait indications
   input wire logic clk_i,
   input wire logic acq_wait_i,
   input wire logic frame_wait_i,
   // Trigger pins
   output logic acq_pin_o,
   output logic frame_pin_o
);
   initial begin
      acq_pin_o = 1'b0;
      frame_pin_o = 1'b0;
   end
   // Blind mode is how the bench overtriggers on purpose
   task automatic fire(input bit frame, input bit polite);
      int n;
      n = 0;
      while (polite && n < 2000 && (frame ? frame_wait_i : acq_wait_i) !== 1'b1) begin
         @(posedge clk_i);
         n++;
      end
      @(posedge clk_i);
      if (frame) frame_pin_o <= 1'b1;
      else acq_pin_o <= 1'b1;
      // Long enough to cross the input synchroniser
      repeat (4) @(posedge clk_i);
      acq_pin_o <= 1'b0;
      frame_pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [verilog/acq_status_pkg.sv]
// Function
// - Flash window high while window open.
// - Global shutter: flash equals exposure active.
// - Software selects flash window for line 1.
// - Early software acquisition trigger dropped, overtrigger.
// - Early software frame trigger dropped, overtrigger.
// - Selector picks acquisition or frame wait status.
// - Status reads true while waiting for selection.
// - Early hardware acquisition trigger dropped, overtrigger.
// - Early hardware frame trigger dropped, overtrigger.
// - Acquisition wait rises on entering wait state.
// - Acquisition wait falls when trigger accepted.
// - Acquisition wait rises again only on re-entry.
// - Acquisition wait only with hardware triggering enabled.
// - Frame wait output shows frame-start waiting.
// - Frame wait rises on entry, falls on trigger.
// - Frame wait only with hardware frame triggering.
`default_nettype none
package acq_status_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   // Register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS_SEL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_SW_TRIG = 8'h0C;
   localparam logic [7:0] OFS_FRAME_COUNT = 8'h10;
   localparam logic [7:0] OFS_EXPOSURE = 8'h14;
   localparam logic [7:0] OFS_READOUT = 8'h18;
   localparam logic [7:0] OFS_FLASH_DELAY = 8'h1C;
   localparam logic [7:0] OFS_OVERTRIG = 8'h20;
   // Control field positions
   localparam int CTRL_ACQ_HW_EN = 0;
   localparam int CTRL_FRAME_HW_EN = 1;
   localparam int CTRL_FRAME_TRIG_ON = 2;
   localparam int CTRL_ROLLING = 3;
   localparam int CTRL_LINE_SRC_LSB = 4;
   localparam int CTRL_W = 7;
   localparam int SW_TRIG_ACQ = 0;
   localparam int SW_TRIG_FRAME = 1;
   // Reset values
   localparam logic [6:0] CTRL_RST = 7'h00;
   localparam logic [15:0] FRAME_COUNT_RST = 16'h0001;
   localparam logic [15:0] EXPOSURE_RST = 16'h0064;
   localparam logic [15:0] READOUT_RST = 16'h00C8;
   localparam logic [15:0] FLASH_DELAY_RST = 16'h0000;
   // Line 1 sources
   localparam logic [2:0] LSRC_LOW = 3'h0;
   localparam logic [2:0] LSRC_EXPOSURE = 3'h1;
   localparam logic [2:0] LSRC_FLASH = 3'h2;
   localparam logic [2:0] LSRC_ACQ_WAIT = 3'h3;
   localparam logic [2:0] LSRC_FRAME_WAIT = 3'h4;
   typedef enum logic [1:0] {
      ST_WAIT_ACQ,
      ST_WAIT_FRAME,
      ST_EXPOSE,
      ST_READOUT
   } acq_state_e;
endpackage
`default_nettype wire

// [verilog/acquisition_trigger_status.sv]
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module acquisition_trigger_status
   import acq_status_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [acq_status_pkg::ADDR_W-1:0] addr_i,
   input wire logic [acq_status_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [acq_status_pkg::DATA_W-1:0] rdata_o,
   // Hardware trigger pins
   input wire logic ext_acq_start_trigger_in_i,
   input wire logic ext_frame_start_trigger_in_i,
   // Monitoring outputs
   output logic exposure_active_out_o,
   output logic flash_window_out_o,
   output logic acq_trigger_wait_o,
   output logic frame_trigger_wait_o,
   output logic line1_out_o,
   // Overtrigger events
   output logic acq_overtrig_o,
   output logic frame_overtrig_o
);
   import acq_status_pkg::*;

   logic rst_meta_reg;
   logic rst_n;
   logic [CTRL_W-1:0] ctrl_reg;
   logic status_sel_reg;
   logic [CNT_W-1:0] frame_count_reg;
   logic [CNT_W-1:0] exposure_reg;
   logic [CNT_W-1:0] readout_reg;
   logic [CNT_W-1:0] flash_delay_reg;
   acq_state_e state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [CNT_W-1:0] frames_left_reg, frames_left_next;
   logic hw_acq_rise, hw_frame_rise;
   logic sw_acq, sw_frame;
   logic acq_trig, frame_trig;
   logic acq_drop, frame_drop;
   logic [CNT_W-1:0] acq_tally, frame_tally;
   logic ovt_clr;
   logic exp_next, flash_next, acq_wait_next, frame_wait_next;
   logic line_next;
   logic acq_hw_en, frame_hw_en, frame_trig_on, rolling;
   logic [2:0] line_src;
   logic wr_hit;

   function automatic logic [CNT_W-1:0] at_least_one(input logic [CNT_W-1:0] v);
      at_least_one = (v == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : v;
   endfunction

   // Reset released through two flops
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   assign acq_hw_en = ctrl_reg[CTRL_ACQ_HW_EN];
   assign frame_hw_en = ctrl_reg[CTRL_FRAME_HW_EN];
   assign frame_trig_on = ctrl_reg[CTRL_FRAME_TRIG_ON];
   assign rolling = ctrl_reg[CTRL_ROLLING];
   assign line_src = ctrl_reg[CTRL_LINE_SRC_LSB +: 3];
   assign wr_hit = wr_i;

   // Register writes
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= CTRL_RST;
         status_sel_reg <= 1'b0;
         frame_count_reg <= FRAME_COUNT_RST;
         exposure_reg <= EXPOSURE_RST;
         readout_reg <= READOUT_RST;
         flash_delay_reg <= FLASH_DELAY_RST;
      end else if (wr_hit) begin
         case (addr_i)
            OFS_CTRL: ctrl_reg <= wdata_i[CTRL_W-1:0];
            OFS_STATUS_SEL: status_sel_reg <= wdata_i[0];
            OFS_FRAME_COUNT: frame_count_reg <= wdata_i[CNT_W-1:0];
            OFS_EXPOSURE: exposure_reg <= wdata_i[CNT_W-1:0];
            OFS_READOUT: readout_reg <= wdata_i[CNT_W-1:0];
            OFS_FLASH_DELAY: flash_delay_reg <= wdata_i[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   assign sw_acq = wr_i && addr_i == OFS_SW_TRIG && wdata_i[SW_TRIG_ACQ];
   assign sw_frame = wr_i && addr_i == OFS_SW_TRIG && wdata_i[SW_TRIG_FRAME];
   assign ovt_clr = wr_i && addr_i == OFS_OVERTRIG;

   pin_edge_sync u_acq_pin (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .pin_i(ext_acq_start_trigger_in_i),
      .rise_o(hw_acq_rise)
   );

   pin_edge_sync u_frame_pin (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .pin_i(ext_frame_start_trigger_in_i),
      .rise_o(hw_frame_rise)
   );

   // Pin edges count only when hardware triggering is on
   assign acq_trig = (acq_hw_en && hw_acq_rise) || sw_acq;
   assign frame_trig = frame_trig_on && ((frame_hw_en && hw_frame_rise) || sw_frame);
   assign acq_drop = acq_trig && state_reg != ST_WAIT_ACQ;
   assign frame_drop = frame_trig && state_reg != ST_WAIT_FRAME;

   overtrig_event #(.CNT_W(CNT_W)) u_acq_ovt (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .hit_i(acq_drop),
      .clr_i(ovt_clr),
      .pulse_o(acq_overtrig_o),
      .count_o(acq_tally)
   );

   overtrig_event #(.CNT_W(CNT_W)) u_frame_ovt (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .hit_i(frame_drop),
      .clr_i(ovt_clr),
      .pulse_o(frame_overtrig_o),
      .count_o(frame_tally)
   );

   // Acquisition sequencer; non-overlapped frames keep the timing simple
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      frames_left_next = frames_left_reg;
      case (state_reg)
         ST_WAIT_ACQ: begin
            if (acq_trig) begin
               state_next = ST_WAIT_FRAME;
               frames_left_next = at_least_one(frame_count_reg);
            end
         end
         ST_WAIT_FRAME: begin
            if (frame_trig || !frame_trig_on) begin
               state_next = ST_EXPOSE;
               cnt_next = '0;
            end
         end
         ST_EXPOSE: begin
            if (cnt_reg >= at_least_one(exposure_reg) - 1'b1) begin
               state_next = ST_READOUT;
               cnt_next = '0;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_READOUT: begin
            if (cnt_reg >= at_least_one(readout_reg) - 1'b1) begin
               cnt_next = '0;
               if (frames_left_reg <= 1) begin
                  state_next = ST_WAIT_ACQ;
                  frames_left_next = '0;
               end else begin
                  state_next = ST_WAIT_FRAME;
                  frames_left_next = frames_left_reg - 1'b1;
               end
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         default: begin
            state_next = ST_WAIT_ACQ;
            cnt_next = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_WAIT_ACQ;
         cnt_reg <= '0;
         frames_left_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         frames_left_reg <= frames_left_next;
      end
   end

   // Outputs registered from the next state so they move with it
   always_comb begin
      exp_next = state_next == ST_EXPOSE;
      // Rolling: window opens once all lines expose
      if (rolling) begin
         flash_next = exp_next && cnt_next >= flash_delay_reg;
      end else begin
         flash_next = exp_next;
      end
      acq_wait_next = acq_hw_en && state_next == ST_WAIT_ACQ;
      frame_wait_next = frame_hw_en && frame_trig_on
         && state_next == ST_WAIT_FRAME;
      case (line_src)
         LSRC_EXPOSURE: line_next = exp_next;
         LSRC_FLASH: line_next = flash_next;
         LSRC_ACQ_WAIT: line_next = acq_wait_next;
         LSRC_FRAME_WAIT: line_next = frame_wait_next;
         default: line_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         exposure_active_out_o <= 1'b0;
         flash_window_out_o <= 1'b0;
         acq_trigger_wait_o <= 1'b0;
         frame_trigger_wait_o <= 1'b0;
         line1_out_o <= 1'b0;
      end else begin
         exposure_active_out_o <= exp_next;
         flash_window_out_o <= flash_next;
         acq_trigger_wait_o <= acq_wait_next;
         frame_trigger_wait_o <= frame_wait_next;
         line1_out_o <= line_next;
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            OFS_CTRL: rdata_o <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
            OFS_STATUS_SEL: rdata_o <= {{(DATA_W-1){1'b0}}, status_sel_reg};
            OFS_STATUS: rdata_o <= {{(DATA_W-1){1'b0}}, status_sel_reg
               ? state_reg == ST_WAIT_FRAME : state_reg == ST_WAIT_ACQ};
            OFS_FRAME_COUNT: rdata_o <= {{(DATA_W-CNT_W){1'b0}}, frame_count_reg};
            OFS_EXPOSURE: rdata_o <= {{(DATA_W-CNT_W){1'b0}}, exposure_reg};
            OFS_READOUT: rdata_o <= {{(DATA_W-CNT_W){1'b0}}, readout_reg};
            OFS_FLASH_DELAY: rdata_o <= {{(DATA_W-CNT_W){1'b0}}, flash_delay_reg};
            OFS_OVERTRIG: rdata_o <= {frame_tally, acq_tally};
            default: rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_acq_taken;
      state_reg == ST_WAIT_ACQ && acq_trig;
   endsequence

   sequence s_frame_gap;
      frame_trig && state_reg != ST_WAIT_FRAME;
   endsequence

   sequence s_frame_taken;
      state_reg == ST_WAIT_FRAME && frame_trig;
   endsequence

   a_acq_drop_pulse: assert property (
      acq_trig && state_reg != ST_WAIT_ACQ |=> acq_overtrig_o)
      else $error("acquisition overtrigger pulse missing");
   a_frame_drop_pulse: assert property (
      s_frame_gap |=> frame_overtrig_o)
      else $error("frame overtrigger pulse missing");
   a_pulse_single: assert property (
      acq_overtrig_o && !$past(acq_drop) |-> 1'b0)
      else $error("spurious acquisition overtrigger pulse");
   a_acq_wait_falls: assert property (
      s_acq_taken ##1 1'b1 |-> !acq_trigger_wait_o)
      else $error("acquisition wait still high after trigger");
   a_acq_wait_enable: assert property (
      acq_trigger_wait_o |-> $past(acq_hw_en) && state_reg == ST_WAIT_ACQ)
      else $error("acquisition wait without hardware enable");
   a_frame_wait_state: assert property (
      frame_trigger_wait_o |-> state_reg == ST_WAIT_FRAME && $past(frame_hw_en))
      else $error("frame wait outside waiting state");
   a_global_flash: assert property (
      !$past(rolling) |-> flash_window_out_o == exposure_active_out_o)
      else $error("flash differs from exposure in global shutter");
   a_flash_in_expose: assert property (
      flash_window_out_o |-> state_reg == ST_EXPOSE)
      else $error("flash window open outside exposure");
   a_line_flash: assert property (
      $past(line_src) == LSRC_FLASH |-> line1_out_o == flash_window_out_o)
      else $error("line 1 does not follow flash window");
   a_acq_wait_rises: assert property (
      state_reg == ST_READOUT && state_next == ST_WAIT_ACQ && acq_hw_en
         |=> acq_trigger_wait_o)
      else $error("acquisition wait did not rise on re-entry");
   a_frame_wait_falls: assert property (
      s_frame_taken ##1 1'b1 |-> !frame_trigger_wait_o)
      else $error("frame wait still high after trigger");
endmodule
`default_nettype wire

// [verilog/overtrig_event.sv]
`timescale 1ns/100ps
`default_nettype none
module overtrig_event #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Discarded trigger and counter clear
   input wire logic hit_i,
   input wire logic clr_i,
   // Event pulse and tally
   output logic pulse_o,
   output logic [CNT_W-1:0] count_o
);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= hit_i;
      end
   end

   // Hit beside a clear still counts; tally saturates
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_o <= '0;
      end else if (clr_i) begin
         count_o <= {{(CNT_W-1){1'b0}}, hit_i};
      end else if (hit_i && count_o != {CNT_W{1'b1}}) begin
         count_o <= count_o + 1'b1;
      end
   end
endmodule
`default_nettype wire

// [verilog/pin_edge_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pin and detected edge
   input wire logic pin_i,
   output logic rise_o
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // First stage read only by the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rise_o <= 1'b0;
      end else begin
         rise_o <= sync_reg & ~last_reg;
      end
   end
endmodule
`default_nettype wire
